/* File: inc/mso_pkg.sv */
package mso_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MOVE_MIN  = 8'h04;
  localparam logic [7:0] OFS_END_RANGE = 8'h08;
  localparam logic [7:0] OFS_END_OFS   = 8'h0C;
  localparam logic [7:0] OFS_SPD_WARN  = 8'h10;
  localparam logic [7:0] OFS_OVL_WARN  = 8'h14;
  localparam logic [7:0] OFS_DEV_WARN  = 8'h18;
  localparam logic [7:0] OFS_OV_WARN   = 8'h1C;
  localparam logic [7:0] OFS_UV_WARN   = 8'h20;
  localparam logic [7:0] OFS_HEAT_WARN = 8'h24;
  localparam logic [7:0] OFS_AREA_BASE = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h40;
  localparam logic [7:0] OFS_ECHO      = 8'h44;
  // control register fields
  localparam int CTRL_HOME_SEL = 0;
  localparam int CTRL_CON_ASGN = 1;
  // reset values
  localparam logic [7:0]  RST_MOVE_MIN  = 8'h00;
  localparam logic [7:0]  RST_END_RANGE = 8'h12;
  localparam logic [7:0]  RST_END_OFS   = 8'h00;
  localparam logic [12:0] RST_SPD_WARN  = 13'h1194;
  localparam logic [8:0]  RST_OVL_WARN  = 9'h032;
  localparam logic [14:0] RST_DEV_WARN  = 15'h012C;
  localparam logic [8:0]  RST_OV_WARN   = 9'h1B3;
  localparam logic [8:0]  RST_UV_WARN   = 9'h078;
  localparam logic [6:0]  RST_HEAT_WARN = 7'h55;
  localparam logic [1:0]  RST_CTRL      = 2'h2;
  // timing: one millisecond tick for minimum on-time
  localparam int CLK_HZ      = 20000000;
  localparam int MS_PER_TICK = 1;
  localparam int MS_CYCLES   = CLK_HZ / 1000 * MS_PER_TICK;
  // overload time unit 0.1 s, counted in ms ticks
  localparam int OVL_UNIT_MS = 100;
  // feedback steps per timing pulse (50 per rev)
  localparam int TIM_PER_REV = 50;
  localparam int ECHO_W      = 26;

  typedef struct packed {
    logic                  mainPower;
    logic                  startAny;
    logic                  freeRun;
    logic                  excite;
    logic                  stopIn;
    logic                  alarm;
    logic                  motorRun;
    logic                  toolBusy;
    logic                  serialBusy;
    logic                  originSet;
    logic                  torqueOver;
    logic                  overloadNow;
    logic signed [23:0]    cmdPos;
    logic signed [23:0]    fbPos;
    logic signed [23:0]    homePos;
    logic [31:0]           devAbs;
    logic [12:0]           speed;
    logic [8:0]            voltage;
    logic [6:0]            temp;
    logic [15:0]           errTenthDeg;
    logic                  shaftStep;
  } mso_motor_t;

  typedef struct packed {
    logic       ready;
    logic       homeInd;
    logic       move;
    logic       posDone;
    logic       torqueLimitFlag;
    logic [2:0] positionWindow;
    logic       shaftTimingPulse;
    logic       internalBusyFlag;
    logic       mainPowerFlag;
    logic [5:0] warn;
  } mso_status_t;
endpackage

/* File: rtl/mso_status_out.sv */
// Our own choices: the APB register port and the placing of the registers.
module mso_status_out
(
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire mso_pkg::mso_motor_t         motor,
  input  wire logic [mso_pkg::ECHO_W-1:0]  echoIn,
  output mso_pkg::mso_status_t             status,
  output logic      [mso_pkg::ECHO_W-1:0]  echoOut
);
  import mso_pkg::*;

  logic [1:0]         ctrl_q;
  logic [7:0]         moveMin_q;
  logic [7:0]         endRange_q;
  logic signed [7:0]  endOfs_q;
  logic [12:0]        spdWarn_q;
  logic [8:0]         ovlWarn_q;
  logic [14:0]        devWarn_q;
  logic [8:0]         ovWarn_q;
  logic [8:0]         uvWarn_q;
  logic [6:0]         heatWarn_q;
  logic signed [23:0] areaPos_q [3];
  logic signed [23:0] areaNeg_q [3];
  mso_status_t        stat_q;
  mso_status_t        stat_d;
  logic [ECHO_W-1:0]  echo_q;
  logic [15:0]        msCnt_q;
  logic               msTick;
  logic [7:0]         moveHold_q;
  logic [15:0]        moveSub_q;
  logic [15:0]        ovlMs_q;
  logic [5:0]         timCnt_q;
  logic               homeHeld_q;
  logic               wrEn;
  logic               rdEn;
  logic               hit;

  // window test shared by all three comparators
  function automatic logic in_window(input logic signed [23:0] pos,
                                     input logic signed [23:0] posB,
                                     input logic signed [23:0] negB);
    logic r;
    r = 1'b0;
    if (posB < negB)
      r = (pos <= posB) || (pos >= negB);
    else if (posB > negB)
      r = (pos >= negB) && (pos <= posB);
    else
      r = (pos == posB);
    return r;
  endfunction

  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !pwrite;
  assign hit     = (paddr <= OFS_ECHO) && (paddr[1:0] == 2'h0)
                   && !(paddr > OFS_AREA_BASE + 8'h14 && paddr < OFS_STATUS);
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q     <= RST_CTRL;
      moveMin_q  <= RST_MOVE_MIN;
      endRange_q <= RST_END_RANGE;
      endOfs_q   <= RST_END_OFS;
      spdWarn_q  <= RST_SPD_WARN;
      ovlWarn_q  <= RST_OVL_WARN;
      devWarn_q  <= RST_DEV_WARN;
      ovWarn_q   <= RST_OV_WARN;
      uvWarn_q   <= RST_UV_WARN;
      heatWarn_q <= RST_HEAT_WARN;
      for (int i = 0; i < 3; i++)
      begin
        areaPos_q[i] <= 24'h000000;
        areaNeg_q[i] <= 24'h000000;
      end
    end
    else if (wrEn)
    begin
      case (paddr)
        OFS_CTRL:      ctrl_q     <= pwdata[1:0];
        OFS_MOVE_MIN:  moveMin_q  <= pwdata[7:0];
        OFS_END_RANGE: endRange_q <= pwdata[7:0];
        OFS_END_OFS:   endOfs_q   <= pwdata[7:0];
        OFS_SPD_WARN:  spdWarn_q  <= pwdata[12:0];
        OFS_OVL_WARN:  ovlWarn_q  <= pwdata[8:0];
        OFS_DEV_WARN:  devWarn_q  <= pwdata[14:0];
        OFS_OV_WARN:   ovWarn_q   <= pwdata[8:0];
        OFS_UV_WARN:   uvWarn_q   <= pwdata[8:0];
        OFS_HEAT_WARN: heatWarn_q <= pwdata[6:0];
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (paddr == OFS_AREA_BASE + 8'(8 * i))
              areaPos_q[i] <= pwdata[23:0];
            if (paddr == OFS_AREA_BASE + 8'(8 * i + 4))
              areaNeg_q[i] <= pwdata[23:0];
          end
        end
      endcase
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    if (rdEn)
    begin
      case (paddr)
        OFS_CTRL:      prdata = {30'h0, ctrl_q};
        OFS_MOVE_MIN:  prdata = {24'h0, moveMin_q};
        OFS_END_RANGE: prdata = {24'h0, endRange_q};
        OFS_END_OFS:   prdata = {{24{endOfs_q[7]}}, endOfs_q};
        OFS_SPD_WARN:  prdata = {19'h0, spdWarn_q};
        OFS_OVL_WARN:  prdata = {23'h0, ovlWarn_q};
        OFS_DEV_WARN:  prdata = {17'h0, devWarn_q};
        OFS_OV_WARN:   prdata = {23'h0, ovWarn_q};
        OFS_UV_WARN:   prdata = {23'h0, uvWarn_q};
        OFS_HEAT_WARN: prdata = {25'h0, heatWarn_q};
        OFS_STATUS:    prdata = {12'h0, 20'(stat_q)};
        OFS_ECHO:      prdata = {6'h0, echo_q};
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (paddr == OFS_AREA_BASE + 8'(8 * i))
              prdata = {{8{areaPos_q[i][23]}}, areaPos_q[i]};
            if (paddr == OFS_AREA_BASE + 8'(8 * i + 4))
              prdata = {{8{areaNeg_q[i][23]}}, areaNeg_q[i]};
          end
        end
      endcase
    end
  end

  // millisecond timebase for overload timing
  assign msTick = (msCnt_q == 16'(MS_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      msCnt_q <= 16'h0000;
    else
      msCnt_q <= msTick ? 16'h0000 : msCnt_q + 16'h0001;
  end

  // minimum move on-time
  // own ms phase restarted by each run cycle, so the stretch is exact
  // rather than short by up to one free-running tick
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      moveHold_q <= 8'h00;
      moveSub_q  <= 16'h0000;
    end
    else if (motor.motorRun)
    begin
      moveHold_q <= moveMin_q;
      moveSub_q  <= 16'h0000;
    end
    else if (moveHold_q != 8'h00)
    begin
      if (moveSub_q == 16'(MS_CYCLES - 1))
      begin
        moveSub_q  <= 16'h0000;
        moveHold_q <= moveHold_q - 8'h01;
      end
      else
        moveSub_q <= moveSub_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ovlMs_q <= 16'h0000;
    else if (!motor.overloadNow)
      ovlMs_q <= 16'h0000;
    else if (msTick && ovlMs_q != 16'hFFFF)
      ovlMs_q <= ovlMs_q + 16'h0001;
  end

  // divide shaft steps into timing pulses
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      timCnt_q <= 6'h00;
    else if (motor.shaftStep)
      timCnt_q <= (timCnt_q == 6'(TIM_PER_REV - 1)) ? 6'h00
                  : timCnt_q + 6'h01;
  end

  // latch home until origin is left
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      homeHeld_q <= 1'b0;
    else if (!motor.originSet || motor.cmdPos != motor.homePos)
      homeHeld_q <= 1'b0;
    else if (stat_d.homeInd)
      homeHeld_q <= 1'b1;
  end

  always_comb
  begin
    logic        moveNow;
    logic signed [17:0] err;
    moveNow = motor.motorRun || (moveHold_q != 8'h00);
    err     = 18'($signed(motor.errTenthDeg)) - 18'(endOfs_q);
    stat_d  = '0;
    stat_d.move = moveNow;
    stat_d.ready = motor.mainPower && !motor.startAny && !motor.freeRun
      && (motor.excite || !ctrl_q[CTRL_CON_ASGN]) && !motor.stopIn
      && !motor.alarm && !moveNow && !motor.toolBusy
      && !motor.serialBusy;
    if (!motor.originSet)
      stat_d.homeInd = 1'b0;
    else if (ctrl_q[CTRL_HOME_SEL])
      stat_d.homeInd = 1'b1;
    else
      stat_d.homeInd = (motor.cmdPos == motor.homePos && !moveNow)
                       || homeHeld_q;
    // completion window with offset
    // signed compare: an unsigned bound would turn the lower limit huge
    stat_d.posDone = !moveNow && (err <= $signed(18'(endRange_q)))
                     && (err >= -$signed(18'(endRange_q)));
    stat_d.torqueLimitFlag = motor.torqueOver;
    stat_d.positionWindow[0] = in_window(motor.cmdPos, areaPos_q[0],
                                         areaNeg_q[0]);
    stat_d.positionWindow[1] = in_window(motor.cmdPos, areaPos_q[1],
                                         areaNeg_q[1]);
    stat_d.positionWindow[2] = in_window(motor.fbPos, areaPos_q[2],
                                         areaNeg_q[2]);
    stat_d.shaftTimingPulse = (timCnt_q == 6'h00);
    stat_d.internalBusyFlag = motor.serialBusy;
    stat_d.mainPowerFlag    = motor.mainPower;
    stat_d.warn[0] = motor.speed > spdWarn_q;
    stat_d.warn[1] = ovlMs_q >= 16'(ovlWarn_q) * 16'(OVL_UNIT_MS);
    stat_d.warn[2] = motor.excite && (motor.devAbs > 32'(devWarn_q));
    stat_d.warn[3] = motor.voltage > ovWarn_q;
    stat_d.warn[4] = motor.voltage < uvWarn_q;
    stat_d.warn[5] = motor.temp >= heatWarn_q;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      stat_q <= '0;
    else
      stat_q <= stat_d;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      echo_q <= '0;
    else
      echo_q <= echoIn;
  end

  assign status  = stat_q;
  assign echoOut = echo_q;

  a_ready_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    stat_q.ready |-> stat_q.mainPowerFlag && !stat_q.move)
    else $error("ready while moving or unpowered");
  a_home_origin: assert property (@(posedge ref_clk) disable iff (!rstn)
    !motor.originSet |=> !stat_q.homeInd)
    else $error("home without origin");
  a_home_sel1: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_q[CTRL_HOME_SEL] && motor.originSet |=> stat_q.homeInd)
    else $error("home not shown with origin set");
  a_done_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    stat_q.posDone |-> !stat_q.move)
    else $error("done while moving");
  a_move_run: assert property (@(posedge ref_clk) disable iff (!rstn)
    motor.motorRun |=> stat_q.move)
    else $error("move missing while running");
  a_area_eq: assert property (@(posedge ref_clk) disable iff (!rstn)
    areaPos_q[0] == areaNeg_q[0] && motor.cmdPos != areaPos_q[0]
    |=> !stat_q.positionWindow[0])
    else $error("equal bound window wrong");
  a_power_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 stat_q.mainPowerFlag == $past(motor.mainPower))
    else $error("power flag mismatch");
  a_echo_copy: assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 echo_q == $past(echoIn))
    else $error("echo mismatch");
  a_busy_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    motor.serialBusy |=> stat_q.internalBusyFlag && !stat_q.ready)
    else $error("busy not shown");
endmodule

/* File: dv/mso_host_model.sv */
module mso_host_model
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire mso_pkg::mso_status_t status,
  input  wire logic                 want,
  output logic                      startCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import mso_pkg::*;
  // start only after ready
  // a pending request waits on ready instead of firing blind
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      startCmd <= 1'b0;
    else if (!want)
      startCmd <= 1'b0;
    else if (status.ready)
      startCmd <= 1'b1;
endmodule

/* File: dv/mso_status_out_tb_top.sv */
module mso_status_out_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mso_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic [31:0]       rdv;
  logic              pready;
  logic              pslverr;
  logic              errv;
  logic              want = 1'b0;
  logic              hostStart;
  logic              tPrev = 1'b0;
  logic [ECHO_W-1:0] echoIn = '0;
  logic [ECHO_W-1:0] echoOut;
  mso_motor_t        mIn = '0;
  mso_motor_t        motor;
  mso_motor_t        base;
  mso_motor_t        m;
  mso_status_t       status;
  int                fail_count = 0;
  int                total_checks = 0;
  int                seed = 7;
  int                tRise = 0;
  int                p;
  int                n;
  int                x;
  int                w;

  // start input seen by the block is the bench level or the host request
  always_comb
  begin
    motor = mIn;
    motor.startAny = mIn.startAny | hostStart;
  end

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    tPrev <= status.shaftTimingPulse;
    if (status.shaftTimingPulse === 1'b1 && tPrev === 1'b0)
      tRise++;
  end

  mso_status_out dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor(motor),
    .echoIn(echoIn), .status(status), .echoOut(echoOut));

  mso_host_model host_u (.ref_clk(ref_clk), .rstn(rstn), .status(status),
    .want(want), .startCmd(hostStart));

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic setm();
    @(posedge ref_clk);
    mIn <= m;
    tick(3);
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
  endtask

  function automatic logic winExp(int pb, int nb, int pos);
    if (pb < nb)
      return pos <= pb || pos >= nb;
    if (pb > nb)
      return pos >= nb && pos <= pb;
    return pos == pb;
  endfunction

  initial
  begin
    base = '0;
    base.mainPower = 1'b1;
    base.excite = 1'b1;
    base.voltage = 9'd200;
    base.temp = 7'd25;
    base.homePos = 24'sd100;
    m = base;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    setm();
    apb(0, OFS_CTRL, 0);
    chk(rdv, 32'h2); // control default
    apb(0, OFS_END_RANGE, 0);
    chk(rdv, 32'h12); // range default
    apb(0, OFS_SPD_WARN, 0);
    chk(rdv, 32'h1194); // speed default
    apb(0, 8'hFC, 0);
    chk({31'h0, errv}, 32'h1); // unmapped refused
    chk(rdv, 32'h0); // unmapped reads zero
    for (int i = 0; i < 10; i++)
    begin
      m = base;
      case (i)
        1: m.mainPower = 1'b0;
        2: m.startAny = 1'b1;
        3: m.freeRun = 1'b1;
        4: m.excite = 1'b0;
        5: m.stopIn = 1'b1;
        6: m.alarm = 1'b1;
        7: m.toolBusy = 1'b1;
        8: m.serialBusy = 1'b1;
        9: m.motorRun = 1'b1;
        default: ;
      endcase
      setm();
      chk(status.ready, i == 0); // ready terms
      chk(status.mainPowerFlag, m.mainPower); // power flag
      if (i == 0 || i == 8)
        chk(status.internalBusyFlag, i == 8); // busy flag
    end
    m = base;
    m.alarm = 1'b1;
    setm();
    @(posedge ref_clk);
    want <= 1'b1;
    tick(4);
    chk(hostStart, 0); // host waits
    m.alarm = 1'b0;
    setm();
    tick(2);
    chk({hostStart, status.ready}, 2'b10); // start blocks ready
    @(posedge ref_clk);
    want <= 1'b0;
    m = base;
    m.originSet = 1'b1;
    m.cmdPos = m.homePos;
    setm();
    chk(status.homeInd, 1); // at home
    m.cmdPos = m.homePos + 24'sd1;
    setm();
    chk(status.homeInd, 0); // moved away
    m.originSet = 1'b0;
    m.cmdPos = m.homePos;
    setm();
    chk(status.homeInd, 0); // no origin
    apb(1, OFS_CTRL, 32'h3);
    m.originSet = 1'b1;
    m.cmdPos = 24'sd7;
    setm();
    chk(status.homeInd, 1); // origin set
    apb(1, OFS_CTRL, 32'h2);
    m = base;
    m.errTenthDeg = 16'd10;
    m.torqueOver = 1'b1;
    m.speed = 13'd4501;
    setm();
    chk({status.posDone, status.torqueLimitFlag}, 2'b11); // flags
    chk(status.warn, 6'h01); // overspeed
    m.errTenthDeg = 16'd30;
    m.speed = 13'd4500;
    m.voltage = 9'd436;
    m.temp = 7'd85;
    m.devAbs = 32'd301;
    setm();
    chk(status.posDone, 0); // out of range
    chk(status.warn, 6'h2C); // deviation, volts, heat
    apb(1, OFS_END_OFS, 32'hC);
    tick(2);
    chk(status.posDone, 1); // offset shifts window
    m.excite = 1'b0;
    m.voltage = 9'd119;
    m.temp = 7'd84;
    setm();
    chk(status.warn, 6'h10); // not excited, undervolt
    for (int i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      echoIn <= ECHO_W'($random(seed));
      tick(2);
      chk(echoOut, echoIn); // echo mirror
    end
    for (int i = 0; i < 40; i++)
    begin
      p = $random(seed) % 6;
      n = $random(seed) % 6;
      w = (i % 2) * 2;
      apb(1, OFS_AREA_BASE + 8'(8 * w), 32'(p));
      apb(1, OFS_AREA_BASE + 8'(8 * w + 4), 32'(n));
      m = base;
      m.cmdPos = 24'($random(seed) % 6);
      m.fbPos = 24'($random(seed) % 6);
      setm();
      x = (w == 0) ? m.cmdPos : m.fbPos;
      chk(status.positionWindow[w], winExp(p, n, x));
    end
    tRise = 0;
    // step count kept a whole multiple of fifty
    for (int i = 0; i < 150; i++)
    begin
      @(posedge ref_clk);
      mIn.shaftStep <= 1'b1;
      @(posedge ref_clk);
      mIn.shaftStep <= 1'b0;
    end
    tick(3);
    chk(tRise, 3); // one per fifty steps
    apb(1, OFS_MOVE_MIN, 32'h1);
    apb(0, OFS_MOVE_MIN, 0);
    chk(rdv, 32'h1); // on-time setting
    m = base;
    m.motorRun = 1'b1;
    setm();
    @(posedge ref_clk);
    mIn.motorRun <= 1'b0;
    tick(MS_CYCLES - 100);
    chk(status.move, 1); // stretched
    tick(200);
    chk(status.move, 0); // released
    stop_test();
  end
endmodule
